// ===== hdl/gdrc_pkg.sv
// constants for the graphics debug reset controller
// assumes a single 100 MHz core clock and a simple config-space port
package gdrc_pkg;
  localparam logic [7:0] GDRC_CTRL_OFFSET = 8'hc0;
  localparam logic [7:0] GDRC_CTRL_RESET = 8'h00;
  localparam int GDRC_REQ_BIT = 0;
  localparam int GDRC_DONE_BIT = 1;
  localparam int GDRC_CLK_MHZ = 100;
  localparam int GDRC_MIN_HOLD_US = 20;
  localparam int GDRC_MIN_HOLD_CYC = GDRC_MIN_HOLD_US * GDRC_CLK_MHZ;
  localparam int GDRC_SEQ_CYC = 16;
  localparam int GDRC_SYNC_STAGES = 3;
  typedef enum logic [1:0] {
    GDRC_IDLE = 2'b00,
    GDRC_ASSERT = 2'b01,
    GDRC_HELD = 2'b10
  } gdrc_state_e;
endpackage

// ===== hdl/gdrc_sync.sv
// three-flop synchroniser with agreement filter
// assumes an asynchronous level input
`timescale 1ns/1ps
module gdrc_sync (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic level_out
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } gdrc_sync_s;
  gdrc_sync_s st_reg;
  gdrc_sync_s st_next;
  always_comb begin
    st_next = st_reg;
    st_next.stage = {st_reg.stage[1:0], async_in};
    // first stage feeds only the second
    if (st_reg.stage[1] == st_reg.stage[2]) begin
      st_next.level = st_reg.stage[2];
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_out = st_reg.level;
endmodule

// ===== hdl/gdrc_seq_timer.sv
// debug reset sequence timer: counts after start, flags done
// assumes start held high for the whole sequence
`timescale 1ns/1ps
module gdrc_seq_timer #(
  parameter int CYCLES = gdrc_pkg::GDRC_SEQ_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  output logic done_out
);
  import gdrc_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  initial begin
    if (CYCLES < 1) $error("gdrc_seq_timer: CYCLES must be at least 1");
  end
  typedef struct packed {
    logic [CW-1:0] count;
    logic done;
  } gdrc_tmr_s;
  gdrc_tmr_s st_reg;
  gdrc_tmr_s st_next;
  always_comb begin
    st_next = st_reg;
    if (!start_in) begin
      st_next = '0;
    end else if (st_reg.count == CW'(CYCLES)) begin
      st_next.done = 1'b1;
    end else begin
      st_next.count = st_reg.count + CW'(1);
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign done_out = st_reg.done;
endmodule

// ===== hdl/gdrc_top.sv
// graphics debug reset controller with its config-space register
// assumes config accesses are single-cycle strobes on the core clock;
// graphics domains report their in-reset state on asynchronous pins
`timescale 1ns/1ps
module gdrc_top #(
  parameter int SEQ_CYCLES = gdrc_pkg::GDRC_SEQ_CYC
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // config space port
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  output logic [7:0] cfg_rdata_out,
  output logic cfg_ack_out,
  input wire logic reg_lock_in,
  // in-reset acknowledgement from render and display domains
  input wire logic render_in_reset_in,
  input wire logic display_in_reset_in,
  // reset and halt controls to the graphics engine
  output logic render_reset_n_out,
  output logic display_reset_n_out,
  output logic mmio_regs_reset_out,
  output logic ring_ptr_reset_out,
  output logic cmd_fetch_drop_out,
  output logic pipe_halt_out,
  output logic fsm_reset_out,
  output logic display_halt_out,
  output logic pending_abandon_out,
  // legacy vga memory and io access gating, and the reset done flag
  input wire logic vga_req_in,
  input wire logic io_req_in,
  output logic vga_grant_out,
  output logic io_grant_out,
  output logic reset_done_flag_out
);
  import gdrc_pkg::*;

  initial begin
    if (SEQ_CYCLES < 1) $error("gdrc_top: SEQ_CYCLES must be at least 1");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    gdrc_state_e state;
    logic req;
    logic done;
    logic [7:0] rdata;
    logic ack;
    logic rst_active;
    logic rst_n_hold;
    logic vga_grant;
    logic io_grant;
  } gdrc_top_s;

  gdrc_top_s st_reg;
  gdrc_top_s st_next;
  logic render_ack;
  logic display_ack;
  logic seq_done;
  logic hit;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  gdrc_sync u_sync_render (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(render_in_reset_in),
    .level_out(render_ack)
  );

  gdrc_sync u_sync_display (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(display_in_reset_in),
    .level_out(display_ack)
  );

  gdrc_seq_timer #(
    .CYCLES(SEQ_CYCLES)
  ) u_seq (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(st_reg.req),
    .done_out(seq_done)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  assign hit = (cfg_addr_in == GDRC_CTRL_OFFSET);

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    // config space always served, even during reset
    if ((cfg_wr_in || cfg_rd_in)) begin
      st_next.ack = 1'b1;
    end
    if (cfg_wr_in && hit && !reg_lock_in) begin
      st_next.req = cfg_wdata_in[GDRC_REQ_BIT];
    end
    st_next.rdata = 8'h00;
    if (cfg_rd_in && hit) begin
      st_next.rdata[GDRC_REQ_BIT] = st_reg.req;
      st_next.rdata[GDRC_DONE_BIT] = st_reg.done;
    end
    unique case (st_reg.state)
      GDRC_IDLE: begin
        st_next.rst_active = 1'b0;
        st_next.done = 1'b0;
        if (st_next.req) begin
          st_next.state = GDRC_ASSERT;
          st_next.rst_active = 1'b1;
        end
      end
      GDRC_ASSERT: begin
        st_next.rst_active = 1'b1;
        if (!st_next.req) begin
          st_next.state = GDRC_IDLE;
          st_next.rst_active = 1'b0;
          st_next.done = 1'b0;
        end else if (seq_done && render_ack && display_ack) begin
          st_next.state = GDRC_HELD;
          st_next.done = 1'b1;
        end
      end
      GDRC_HELD: begin
        if (!st_next.req) begin
          st_next.state = GDRC_IDLE;
          st_next.rst_active = 1'b0;
          st_next.done = 1'b0;
        end
      end
      default: begin
        st_next.state = GDRC_IDLE;
      end
    endcase
    // access gating follows the held request
    st_next.rst_n_hold = !st_next.rst_active;
    st_next.vga_grant = vga_req_in && !st_next.rst_active;
    st_next.io_grant = io_req_in && !st_next.rst_active;
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '0;
      st_reg.state <= GDRC_IDLE;
      st_reg.rst_n_hold <= 1'b1;
      st_reg.req <= GDRC_CTRL_RESET[GDRC_REQ_BIT];
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cfg_rdata_out = st_reg.rdata;
  assign cfg_ack_out = st_reg.ack;
  assign render_reset_n_out = st_reg.rst_n_hold;
  assign display_reset_n_out = st_reg.rst_n_hold;
  assign mmio_regs_reset_out = st_reg.rst_active;
  assign ring_ptr_reset_out = st_reg.rst_active;
  assign cmd_fetch_drop_out = st_reg.rst_active;
  assign pipe_halt_out = st_reg.rst_active;
  assign fsm_reset_out = st_reg.rst_active;
  assign display_halt_out = st_reg.rst_active;
  assign pending_abandon_out = st_reg.rst_active;
  assign vga_grant_out = st_reg.vga_grant;
  assign io_grant_out = st_reg.io_grant;
  assign reset_done_flag_out = st_reg.done;
endmodule

// ===== dv/gdrc_sva.sv
// assertions on the ports of gdrc_top
// assumes bind onto gdrc_top with matching port names
`timescale 1ns/1ps
module gdrc_sva (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [7:0] cfg_addr_in,
  input wire logic [7:0] cfg_wdata_in,
  input wire logic cfg_ack_out,
  input wire logic reg_lock_in,
  input wire logic render_reset_n_out,
  input wire logic display_reset_n_out,
  input wire logic mmio_regs_reset_out,
  input wire logic ring_ptr_reset_out,
  input wire logic cmd_fetch_drop_out,
  input wire logic pipe_halt_out,
  input wire logic fsm_reset_out,
  input wire logic display_halt_out,
  input wire logic pending_abandon_out,
  input wire logic vga_grant_out,
  input wire logic io_grant_out,
  input wire logic reset_done_flag_out
);
  // --------------------------------
  // config accesses and the reset, halt, grant and done outputs
  // --------------------------------
  logic wr_ok;
  logic held;
  assign wr_ok = cfg_wr_in && cfg_addr_in == 8'hc0 && !reg_lock_in;
  assign held = !render_reset_n_out;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_req_sets_reset: assert property (wr_ok && cfg_wdata_in[0] |=> held && !display_reset_n_out)
    else $error("reset not asserted after request");
  a_clr_releases: assert property (wr_ok && !cfg_wdata_in[0] |=> !held && display_reset_n_out)
    else $error("reset not released after clear");
  a_clr_drops_done: assert property (wr_ok && !cfg_wdata_in[0] |=> !reset_done_flag_out)
    else $error("done flag kept after clear");
  a_done_needs_held: assert property (reset_done_flag_out |-> held && !display_reset_n_out)
    else $error("done flag without reset held");
  a_state_reset: assert property ({mmio_regs_reset_out, ring_ptr_reset_out, fsm_reset_out} == {3{held}})
    else $error("state reset outputs disagree");
  a_engine_halt: assert property ({cmd_fetch_drop_out, pipe_halt_out, display_halt_out,
    pending_abandon_out} == {4{held}})
    else $error("halt outputs disagree");
  a_grant_gated: assert property (vga_grant_out || io_grant_out |-> !held)
    else $error("access granted while held");
  a_cfg_acked: assert property (cfg_wr_in || cfg_rd_in |=> cfg_ack_out)
    else $error("config access not acked");
  a_lock_holds: assert property (cfg_wr_in && reg_lock_in |=> $stable(render_reset_n_out))
    else $error("locked write changed reset");
endmodule
bind gdrc_top gdrc_sva u_sva (.*);

// ===== dv/gdrc_top_tb.sv
// self-checking bench for gdrc_top
// assumes gdrc_sva bound in and a short debug sequence
`timescale 1ns/1ps
module gdrc_top_tb;
  logic core_clk_in = '0, rst_n_in = '0, cfg_wr_in = '0, cfg_rd_in = '0, reg_lock_in = '0;
  logic render_in_reset_in = '0, display_in_reset_in = '0, vga_req_in = '1, io_req_in = '1;
  logic [7:0] cfg_addr_in = '0, cfg_wdata_in = '0, cfg_rdata_out, rd;
  logic cfg_ack_out, render_reset_n_out, display_reset_n_out, mmio_regs_reset_out;
  logic ring_ptr_reset_out, cmd_fetch_drop_out, pipe_halt_out, fsm_reset_out;
  logic display_halt_out, pending_abandon_out, vga_grant_out, io_grant_out;
  logic reset_done_flag_out;
  int err_total, n_checks, cyc;
  gdrc_top #(.SEQ_CYCLES(2)) dut (.*);
  always #5 core_clk_in = ~core_clk_in;
  // --------------------------------
  // helpers
  // --------------------------------
  task report_and_stop();
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      report_and_stop();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    #1;
    cfg_wr_in = wr;
    cfg_rd_in = !wr;
    cfg_addr_in = a;
    cfg_wdata_in = d;
    @(posedge core_clk_in);
    #1;
    cfg_wr_in = '0;
    cfg_rd_in = '0;
    rd = cfg_rdata_out;
    chk({7'h00, cfg_ack_out}, 8'h01);
  endtask
  task ctl(input logic [7:0] exp);
    chk({render_reset_n_out, display_reset_n_out, mmio_regs_reset_out, ring_ptr_reset_out,
      cmd_fetch_drop_out, pipe_halt_out, fsm_reset_out, display_halt_out}, exp);
    chk({6'h00, pending_abandon_out, ~vga_grant_out & ~io_grant_out}, {6'h00, {2{~exp[7]}}});
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task t_idle();
    acc(1'h0, 8'hc0, 8'h00);
    chk(rd, 8'h00);
    ctl(8'hc0);
    reg_lock_in = '1;
    acc(1'h1, 8'hc0, 8'h01);
    ctl(8'hc0);
    reg_lock_in = '0;
  endtask
  task t_assert();
    render_in_reset_in = '1;
    acc(1'h1, 8'hc0, 8'hff);
    ctl(8'h3f);
    repeat (20) @(posedge core_clk_in);
    #1;
    chk({7'h00, reset_done_flag_out}, 8'h00);
    acc(1'h0, 8'hc0, 8'h00);
    chk(rd, 8'h01);
    display_in_reset_in = '1;
    for (int i = 0; i < 40 && reset_done_flag_out !== 1'h1; i++) begin
      @(posedge core_clk_in);
      #1;
    end
    acc(1'h0, 8'hc0, 8'h00);
    chk(rd, 8'h03);
    reg_lock_in = '1;
    acc(1'h1, 8'hc0, 8'h00);
    ctl(8'h3f);
    reg_lock_in = '0;
  endtask
  task t_release();
    repeat (2000) @(posedge core_clk_in);
    acc(1'h1, 8'hc0, 8'h00);
    ctl(8'hc0);
    chk({7'h00, reset_done_flag_out}, 8'h00);
    acc(1'h0, 8'hc0, 8'h00);
    chk(rd, 8'h00);
    acc(1'h0, 8'h90, 8'h00);
    chk(rd, 8'h00);
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    #1;
    rst_n_in = '1;
    t_idle();
    t_assert();
    t_release();
    report_and_stop();
  end
endmodule
